//--- nts_pkg.sv
/*
 * Constants shared by the flash host sequencer: command codes, pin timing
 * counts, busy timeouts and partial-program limit.
 * Assumes a 250 MHz clock and a byte-wide asynchronous flash on the far side.
 */
// Summary of operation
// - Host caps partial programs of the last-programmed page at four; an erase or a program of another page restarts the count.
// - Host ends cache programming with the plain load and program-confirm pair.
// - After a cache-confirm end, host refuses reads and erase until a reset or a plain program.
// - Host never drives the byte bus while the flash outputs read data.
// - Command codes in hex; only status read and reset accepted while busy.
// - Byte latched on rising write strobe: command if latch-command high, address if latch-address high, else data.
`default_nettype none
package nts_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Command codes
    localparam logic [7:0] CMD_LOAD      = 8'h80;
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_READ_GO   = 8'h30;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_CACHE_GO  = 8'h15;
    localparam logic [7:0] CMD_ERASE     = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
    localparam logic [7:0] CMD_ID        = 8'h90;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    localparam logic [7:0] CMD_CREAD     = 8'h31;
    localparam logic [7:0] CMD_CREAD_END = 8'h3f;
    localparam logic [7:0] CMD_COPY_GO   = 8'h3a;
    localparam int unsigned STATUS_READY_BIT = 6;
    // Strobe phase lengths: 12 ns pulse, 25 ns cycle, 60 ns write-to-read turn
    localparam int unsigned STROBE_LOW_NS  = 12;
    localparam int unsigned STROBE_HIGH_NS = 13;
    localparam int unsigned TURN_NS        = 60;
    localparam int unsigned BUSY_WAIT_NS   = 100;
    localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TURN_CYC        = (TURN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned BUSY_WAIT_CYC   = (BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;
    // Busy limits in microseconds
    localparam int unsigned ARRAY_FETCH_US        = 25;
    localparam int unsigned CACHE_READ_BUSY_US    = 25;
    localparam int unsigned COPY_READ_BUSY_US     = 30;
    localparam int unsigned CACHE_WRITE_BUSY_US   = 700;
    localparam int unsigned PAGE_PROGRAM_BUSY_US  = 700;
    localparam int unsigned RESET_BUSY_ERASE_US   = 500;
    localparam int unsigned PARTIAL_PROGRAM_LIMIT = 4;
    localparam int unsigned ADDR_BYTES            = 4;
    typedef enum logic [2:0] {
        NTS_OP_READ, NTS_OP_PROG, NTS_OP_CACHE_PROG, NTS_OP_ERASE,
        NTS_OP_STATUS, NTS_OP_RESET, NTS_OP_CACHE_READ, NTS_OP_COPY_READ
    } nts_op_t;
endpackage : nts_pkg
`default_nettype wire

//--- nts_host.sv
/*
 * Host sequencer for a byte-wide asynchronous flash. Takes one operation
 * request, drives the latch, strobe and byte pins, streams data through a
 * two-entry buffer for read data only and waits on ready/busy with a timeout.
 * Assumes pin inputs synchronous to clk_in; ready/busy is pulled up outside.
 */
`default_nettype none
module nts_host #(
    parameter int unsigned DATA_LEN     = 2176,
    parameter int unsigned TIMEOUT_CYC  = 500 * nts_pkg::CLK_MHZ * 2
) (
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // Operation request
    input  wire logic          req_valid_in,
    output logic               req_ready_out,
    input  wire nts_pkg::nts_op_t req_op_in,
    input  wire logic [31:0]   req_addr_in,
    input  wire logic [11:0]   req_len_in,
    output logic               done_out,
    output logic               timeout_out,
    output logic               refused_out,
    output logic [7:0]         status_out,
    // Write data source
    input  wire logic          wr_valid_in,
    output logic               wr_ready_out,
    input  wire logic [7:0]    wr_data_in,
    // Read data sink
    output logic               rd_valid_out,
    input  wire logic          rd_ready_in,
    output logic [7:0]         rd_data_out,
    // Flash pins
    output logic               cmd_latch_out,
    output logic               addr_latch_out,
    output logic               chip_sel_n_out,
    output logic               write_strobe_n_out,
    output logic               output_strobe_n_out,
    output logic [7:0]         io_out,
    output logic               io_oe_out,
    input  wire logic [7:0]    io_in,
    input  wire logic          ready_busy_n_in
);
    initial begin
        if (DATA_LEN == 0 || DATA_LEN > 4095 || TIMEOUT_CYC < 16 || TIMEOUT_CYC > 32'h7fff_ffff)
            $error("nts_host: parameter out of range");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAITB, S_BUSY, S_TURN, S_RDATA, S_STAT, S_DONE
    } nts_state_t;

    nts_state_t  state_reg, state_next;
    nts_pkg::nts_op_t op_reg, op_next;
    logic [31:0] addr_reg, addr_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [31:0] tmr_reg, tmr_next;
    logic [2:0]  ph_reg, ph_next;       // strobe phase counter
    logic        low_reg, low_next;     // strobe in low half
    logic [7:0]  byte_reg, byte_next;
    logic        cl_reg, cl_next, al_reg, al_next, we_reg, we_next, re_reg, re_next, oe_reg, oe_next;
    logic        ce_reg, ce_next, done_reg, done_next, to_reg, to_next, rf_reg, rf_next;
    logic [7:0]  stat_reg, stat_next;
    logic [2:0]  ppc_reg, ppc_next;     // partial program count on last page
    logic [31:0] ppa_reg, ppa_next;
    logic        cache_open_reg, cache_open_next;
    // Two-entry read buffer
    logic [7:0]  buf_mem [2];
    logic [1:0]  bcnt_reg, bcnt_next;
    logic        bwp_reg, bwp_next, brp_reg, brp_next;
    logic        push, pop;

    // Second command byte of each two-cycle operation
    function automatic logic [7:0] confirm_code(input nts_pkg::nts_op_t op);
        case (op)
            nts_pkg::NTS_OP_READ:       confirm_code = nts_pkg::CMD_READ_GO;
            nts_pkg::NTS_OP_COPY_READ:  confirm_code = nts_pkg::CMD_COPY_GO;
            nts_pkg::NTS_OP_PROG:       confirm_code = nts_pkg::CMD_PROG_GO;
            nts_pkg::NTS_OP_CACHE_PROG: confirm_code = nts_pkg::CMD_CACHE_GO;
            default:                    confirm_code = nts_pkg::CMD_ERASE_GO;
        endcase
    endfunction : confirm_code

    function automatic logic [7:0] first_code(input nts_pkg::nts_op_t op, input logic [11:0] len);
        case (op)
            nts_pkg::NTS_OP_READ, nts_pkg::NTS_OP_COPY_READ: first_code = nts_pkg::CMD_READ;
            nts_pkg::NTS_OP_PROG, nts_pkg::NTS_OP_CACHE_PROG: first_code = nts_pkg::CMD_LOAD;
            nts_pkg::NTS_OP_ERASE:      first_code = nts_pkg::CMD_ERASE;
            nts_pkg::NTS_OP_STATUS:     first_code = nts_pkg::CMD_STATUS;
            nts_pkg::NTS_OP_CACHE_READ: first_code = (len[11]) ? nts_pkg::CMD_CREAD_END : nts_pkg::CMD_CREAD;
            default:                    first_code = nts_pkg::CMD_RESET;
        endcase
    endfunction : first_code

    assign req_ready_out = (state_reg == S_IDLE);
    assign push   = (state_reg == S_RDATA) && ph_reg == 3'h0 && low_reg && bcnt_reg != 2'h2;
    assign pop    = rd_valid_out && rd_ready_in;
    assign wr_ready_out = (state_reg == S_WDATA) && ph_reg == 3'h0 && !low_reg && cnt_reg != 12'h000;
    assign rd_valid_out = (bcnt_reg != 2'h0);
    assign rd_data_out  = buf_mem[brp_reg];

    // Pins straight from flops
    assign cmd_latch_out       = cl_reg;
    assign addr_latch_out      = al_reg;
    assign chip_sel_n_out      = ce_reg;
    assign write_strobe_n_out  = we_reg;
    assign output_strobe_n_out = re_reg;
    assign io_out              = byte_reg;
    assign io_oe_out           = oe_reg;
    assign done_out            = done_reg;
    assign timeout_out         = to_reg;
    assign refused_out         = rf_reg;
    assign status_out          = stat_reg;

    // Sequencer: one byte per write strobe, phase counter paces low/high halves
    always_comb begin
        state_next = state_reg; op_next = op_reg; addr_next = addr_reg; cnt_next = cnt_reg;
        tmr_next = tmr_reg; ph_next = ph_reg; low_next = low_reg; byte_next = byte_reg;
        cl_next = cl_reg; al_next = al_reg; we_next = we_reg; re_next = re_reg; oe_next = oe_reg;
        ce_next = ce_reg; done_next = 1'b0; to_next = 1'b0; rf_next = 1'b0; stat_next = stat_reg;
        ppc_next = ppc_reg; ppa_next = ppa_reg; cache_open_next = cache_open_reg;
        if (ph_reg != 3'h0) ph_next = ph_reg - 3'h1;
        case (state_reg)
            S_IDLE: begin
                ce_next = 1'b1; oe_next = 1'b0;
                if (req_valid_in) begin
                    // Only status and reset go out when the flash is busy
                    // Cache programming left open must be closed by reset or a plain program before reads or erase
                    // Partial programs of one page are capped
                    if ((!ready_busy_n_in && req_op_in != nts_pkg::NTS_OP_STATUS
                         && req_op_in != nts_pkg::NTS_OP_RESET)
                        || (cache_open_reg && req_op_in != nts_pkg::NTS_OP_STATUS
                            && req_op_in != nts_pkg::NTS_OP_RESET
                            && req_op_in != nts_pkg::NTS_OP_PROG
                            && req_op_in != nts_pkg::NTS_OP_CACHE_PROG)
                        || (req_op_in == nts_pkg::NTS_OP_PROG && req_addr_in == ppa_reg
                            && ppc_reg >= 3'(nts_pkg::PARTIAL_PROGRAM_LIMIT))) begin
                        rf_next = 1'b1;
                    end else begin
                        op_next = req_op_in; addr_next = req_addr_in; cnt_next = req_len_in;
                        ce_next = 1'b0; cl_next = 1'b1;
                        byte_next = first_code(req_op_in, req_len_in);
                        oe_next = 1'b1; we_next = 1'b0; low_next = 1'b1;
                        ph_next = 3'(nts_pkg::STROBE_LOW_CYC); state_next = S_CMD1;
                    end
                end
            end
            S_CMD1, S_ADDR, S_CMD2: begin
                if (ph_reg == 3'h0 && low_reg) begin
                    we_next = 1'b1; low_next = 1'b0;  // Byte latched on this rising edge
                    ph_next = 3'(nts_pkg::STROBE_HIGH_CYC);
                end else if (ph_reg == 3'h0) begin
                    cl_next = 1'b0; al_next = 1'b0; low_next = 1'b1;
                    ph_next = 3'(nts_pkg::STROBE_LOW_CYC);
                    if (state_reg == S_CMD2 || (state_reg == S_CMD1 && (op_reg == nts_pkg::NTS_OP_RESET
                        || op_reg == nts_pkg::NTS_OP_CACHE_READ))) begin
                        oe_next = 1'b0; tmr_next = 32'(nts_pkg::BUSY_WAIT_CYC); state_next = S_WAITB;
                    end else if (state_reg == S_CMD1 && op_reg == nts_pkg::NTS_OP_STATUS) begin
                        oe_next = 1'b0; tmr_next = 32'(nts_pkg::TURN_CYC); state_next = S_TURN;
                    end else if (state_reg == S_CMD1) begin
                        al_next = 1'b1; we_next = 1'b0; state_next = S_ADDR;
                        byte_next = addr_reg[7:0]; addr_next = {addr_reg[7:0], addr_reg[31:8]};
                        cnt_next = (op_reg == nts_pkg::NTS_OP_ERASE) ? 12'h001 : 12'(nts_pkg::ADDR_BYTES - 1);
                        if (op_reg == nts_pkg::NTS_OP_ERASE) begin
                            byte_next = addr_reg[23:16]; addr_next = {addr_reg[23:0], addr_reg[31:24]};
                        end
                    end else if (cnt_reg != 12'h000) begin
                        al_next = 1'b1; we_next = 1'b0; cnt_next = cnt_reg - 12'h001;
                        byte_next = addr_reg[7:0]; addr_next = {addr_reg[7:0], addr_reg[31:8]};
                    end else if (op_reg == nts_pkg::NTS_OP_PROG || op_reg == nts_pkg::NTS_OP_CACHE_PROG) begin
                        cnt_next = req_len_in; low_next = 1'b0; ph_next = 3'h0; state_next = S_WDATA;
                    end else begin
                        // Reads and erase send their confirm code straight after the address
                        cl_next = 1'b1; we_next = 1'b0; byte_next = confirm_code(op_reg); state_next = S_CMD2;
                    end
                end
            end
            S_WDATA: begin
                // Bus driven only here and in command and address phases, never while reading
                if (wr_ready_out && wr_valid_in) begin
                    byte_next = wr_data_in; we_next = 1'b0; low_next = 1'b1; oe_next = 1'b1;
                    cnt_next = cnt_reg - 12'h001; ph_next = 3'(nts_pkg::STROBE_LOW_CYC);
                end else if (ph_reg == 3'h0 && low_reg) begin
                    we_next = 1'b1; low_next = 1'b0; ph_next = 3'(nts_pkg::STROBE_HIGH_CYC);
                end else if (ph_reg == 3'h0 && cnt_reg == 12'h000) begin
                    cl_next = 1'b1; we_next = 1'b0; low_next = 1'b1;
                    byte_next = confirm_code(op_reg); ph_next = 3'(nts_pkg::STROBE_LOW_CYC); state_next = S_CMD2;
                end
            end
            S_WAITB: begin
                // Allow the flash its write-to-busy delay before sampling ready
                tmr_next = tmr_reg - 32'h1;
                if (tmr_reg == 32'h0) begin
                    tmr_next = TIMEOUT_CYC; state_next = S_BUSY;
                end
            end
            S_BUSY: begin
                // Busy limit: one TIMEOUT_CYC timeout for every operation
                tmr_next = tmr_reg - 32'h1;
                if (ready_busy_n_in) begin
                    if (op_reg == nts_pkg::NTS_OP_PROG) begin
                        ppc_next = (addr_reg == ppa_reg) ? ppc_reg + 3'h1 : 3'h1;
                        ppa_next = addr_reg; cache_open_next = 1'b0;  // Plain program closes cache mode
                    end
                    if (op_reg == nts_pkg::NTS_OP_CACHE_PROG) cache_open_next = 1'b1;
                    if (op_reg == nts_pkg::NTS_OP_RESET) cache_open_next = 1'b0;
                    if (op_reg == nts_pkg::NTS_OP_ERASE) ppc_next = 3'h0;
                    if (op_reg == nts_pkg::NTS_OP_READ || op_reg == nts_pkg::NTS_OP_CACHE_READ
                        || op_reg == nts_pkg::NTS_OP_COPY_READ) begin
                        // Bit 11 only picks the last-page code for cache reads, it is no part of the count
                        cnt_next = (op_reg == nts_pkg::NTS_OP_CACHE_READ) ? {1'b0, req_len_in[10:0]} : req_len_in;
                        tmr_next = 32'(nts_pkg::TURN_CYC); state_next = S_TURN;
                    end else begin
                        state_next = S_DONE;
                    end
                end else if (tmr_reg == 32'h0) begin
                    to_next = 1'b1; ce_next = 1'b1; state_next = S_IDLE;
                end
            end
            S_TURN: begin
                tmr_next = tmr_reg - 32'h1;
                if (tmr_reg == 32'h0) begin
                    re_next = 1'b0; low_next = 1'b1; ph_next = 3'(nts_pkg::STROBE_LOW_CYC);
                    state_next = (op_reg == nts_pkg::NTS_OP_STATUS) ? S_STAT : S_RDATA;
                end
            end
            S_STAT: begin
                // Status byte carries ready at bit six
                // Status byte bypasses the read buffer so it never reaches the data sink
                if (ph_reg == 3'h0 && low_reg) begin
                    stat_next = io_in; re_next = 1'b1; state_next = S_DONE;
                end
            end
            S_RDATA: begin
                // Strobe rises each byte so either output release mode is safe
                if (push) begin
                    re_next = 1'b1; low_next = 1'b0; ph_next = 3'(nts_pkg::STROBE_HIGH_CYC);
                    cnt_next = cnt_reg - 12'h001;
                end else if (ph_reg == 3'h0 && !low_reg) begin
                    if (cnt_reg == 12'h000) state_next = S_DONE;
                    else begin
                        re_next = 1'b0; low_next = 1'b1; ph_next = 3'(nts_pkg::STROBE_LOW_CYC);
                    end
                end
            end
            S_DONE: begin
                ce_next = 1'b1; oe_next = 1'b0; done_next = 1'b1; state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // Read buffer pointers
    always_comb begin
        bcnt_next = bcnt_reg + {1'b0, push} - {1'b0, pop};
        bwp_next  = bwp_reg ^ push;
        brp_next  = brp_reg ^ pop;
    end

    always_ff @(posedge clk_in) begin
        if (push) buf_mem[bwp_reg] <= io_in;
    end

    // Register stage; strobes and chip select idle high, latches low, bus released
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_reg <= S_IDLE; op_reg <= nts_pkg::NTS_OP_RESET; addr_reg <= 32'h0; cnt_reg <= 12'h0;
            tmr_reg <= 32'h0; ph_reg <= 3'h0; low_reg <= 1'b0; byte_reg <= 8'h00;
            cl_reg <= 1'b0; al_reg <= 1'b0; we_reg <= 1'b1; re_reg <= 1'b1; oe_reg <= 1'b0;
            ce_reg <= 1'b1; done_reg <= 1'b0; to_reg <= 1'b0; rf_reg <= 1'b0; stat_reg <= 8'h00;
            ppc_reg <= 3'h0; ppa_reg <= 32'h0; cache_open_reg <= 1'b0;
            bcnt_reg <= 2'h0; bwp_reg <= 1'b0; brp_reg <= 1'b0;
        end else begin
            state_reg <= state_next; op_reg <= op_next; addr_reg <= addr_next; cnt_reg <= cnt_next;
            tmr_reg <= tmr_next; ph_reg <= ph_next; low_reg <= low_next; byte_reg <= byte_next;
            cl_reg <= cl_next; al_reg <= al_next; we_reg <= we_next; re_reg <= re_next; oe_reg <= oe_next;
            ce_reg <= ce_next; done_reg <= done_next; to_reg <= to_next; rf_reg <= rf_next;
            stat_reg <= stat_next; ppc_reg <= ppc_next; ppa_reg <= ppa_next;
            cache_open_reg <= cache_open_next;
            bcnt_reg <= bcnt_next; bwp_reg <= bwp_next; brp_reg <= brp_next;
        end
    end

    a_bus_not_both: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !(io_oe_out && !output_strobe_n_out)) else $error("bus driven during read");
    a_busy_cmd_block: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_IDLE && req_valid_in && !ready_busy_n_in && req_op_in != nts_pkg::NTS_OP_STATUS
         && req_op_in != nts_pkg::NTS_OP_RESET)
        |=> refused_out) else $error("command not refused while busy");
    a_latch_excl: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !(cmd_latch_out && addr_latch_out)) else $error("both latches high");
    a_cmd_on_rise: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $rose(write_strobe_n_out) && cmd_latch_out |-> io_oe_out) else $error("command not driven");
    a_cache_close: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == S_IDLE && req_valid_in && cache_open_reg && ready_busy_n_in
         && req_op_in == nts_pkg::NTS_OP_ERASE) |=> refused_out) else $error("open cache not guarded");
    a_partial_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ppc_reg <= 3'(nts_pkg::PARTIAL_PROGRAM_LIMIT)) else $error("partial program over limit");
    a_timeout_ends: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        timeout_out |-> chip_sel_n_out && state_reg == S_IDLE) else $error("timeout left select");
    a_read_strobe_rise: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        push && state_reg == S_RDATA |=> output_strobe_n_out) else $error("strobe not raised");
endmodule : nts_host
`default_nettype wire

//--- nts_flash_model.sv
/* Behavioural byte-wide flash facing the host sequencer; busy times are shortened.
   Assumes one host on the pins and a pull-up on ready/busy. */
`default_nettype none
module nts_flash_model #(
    parameter int unsigned BUSY_NS = 400
) (
    input  wire logic       cmd_latch_in,
    input  wire logic       addr_latch_in,
    input  wire logic       chip_sel_n_in,
    input  wire logic       write_strobe_n_in,
    input  wire logic       output_strobe_n_in,
    input  wire logic [7:0] host_io_in,
    input  wire logic       host_oe_in,
    input  wire logic       hang_in,
    output logic [7:0]      io_out,
    output logic            ready_busy_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] page_mem [0:4095];
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] dout    = 8'h00;
    logic       ready   = 1'b1;
    logic       drive   = 1'b0;
    int         col     = 0;
    // Busy for a fixed time; a hang keeps ready low so the host must time out
    task automatic go_busy();
        ready = 1'b0;
        fork begin #(BUSY_NS); ready = !hang_in; end join_none
    endtask : go_busy
    // Bytes latched at rising write strobe; status and reset accepted even while busy
    always @(posedge write_strobe_n_in) begin
        if (!chip_sel_n_in && cmd_latch_in) begin
            cmd_reg = host_io_in;
            if (host_io_in inside {8'h00, 8'h31, 8'h3f, 8'h80, 8'hff}) col = 0;
            if (host_io_in inside {8'h30, 8'h10, 8'h15, 8'hd0, 8'hff, 8'h31, 8'h3f, 8'h3a}) go_busy();
        end else if (!chip_sel_n_in && !addr_latch_in && cmd_reg == nts_pkg::CMD_LOAD) begin
            page_mem[col] = host_io_in;
            col = col + 1;
        end
    end
    // Each falling read strobe presents the next column or the status byte
    always @(negedge output_strobe_n_in) begin
        if (!chip_sel_n_in) begin
            drive = 1'b1;
            dout = (cmd_reg == nts_pkg::CMD_STATUS) ? {1'b0, ready, 6'h00} : page_mem[col];
            if (cmd_reg != nts_pkg::CMD_STATUS) col = col + 1;
        end
    end
    always @(posedge output_strobe_n_in) drive = 1'b0;
    // Deselect releases the bus as well, as in the short high phase mode
    always @(posedge chip_sel_n_in) drive = 1'b0;
    // Released bus shows the inverse of the last byte so stale data cannot pass
    assign io_out = host_oe_in ? host_io_in : (drive ? dout : ~dout);
    assign ready_busy_n_out = ready;
endmodule : nts_flash_model
`default_nettype wire

//--- testbench.sv
/* Self-checking bench: host sequencer against the behavioural flash.
   Assumes the model's busy time sits inside the shortened timeout. */
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0, rst_b_in = 1'b0, req_valid_in = 1'b0, wr_valid_in = 1'b0, rd_ready_in = 1'b0, hang = 1'b0;
    nts_pkg::nts_op_t req_op_in = nts_pkg::NTS_OP_STATUS;
    logic [31:0] req_addr_in = 32'h0, seed = 32'h0000a7ff;
    logic [11:0] req_len_in = 12'h000;
    logic [7:0]  wr_data_in = 8'h00, exp_b, page_exp [0:15];
    logic [7:0]  status_out, rd_data_out, io_out, io_in;
    logic req_ready_out, done_out, timeout_out, refused_out, rd_valid_out, wr_ready_out, io_oe_out, ready_busy_n_in;
    logic cmd_latch_out, addr_latch_out, chip_sel_n_out, write_strobe_n_out, output_strobe_n_out;
    logic [7:0]  exp_q [$];
    int errors = 0, checked = 0, wi = 0, wlen = 0;
    always #2 clk_in = ~clk_in;
    nts_host #(.DATA_LEN(16), .TIMEOUT_CYC(200)) nts_host_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_op_in(req_op_in), .req_addr_in(req_addr_in),
        .req_len_in(req_len_in), .done_out(done_out), .timeout_out(timeout_out), .refused_out(refused_out),
        .status_out(status_out), .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in),
        .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
        .cmd_latch_out(cmd_latch_out), .addr_latch_out(addr_latch_out), .chip_sel_n_out(chip_sel_n_out),
        .write_strobe_n_out(write_strobe_n_out), .output_strobe_n_out(output_strobe_n_out), .io_out(io_out),
        .io_oe_out(io_oe_out), .io_in(io_in), .ready_busy_n_in(ready_busy_n_in));
    nts_flash_model #(.BUSY_NS(400)) nts_flash_model_inst (.cmd_latch_in(cmd_latch_out), .addr_latch_in(addr_latch_out),
        .chip_sel_n_in(chip_sel_n_out), .write_strobe_n_in(write_strobe_n_out), .output_strobe_n_in(output_strobe_n_out),
        .host_io_in(io_out), .host_oe_in(io_oe_out), .hang_in(hang), .io_out(io_in), .ready_busy_n_out(ready_busy_n_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic complete_run();
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Streams: reads see pre-edge values, so each handshake is judged as the design sees it
    always @(posedge clk_in) begin
        if (wr_valid_in && wr_ready_out) wi = wi + 1;
        if (rd_valid_out && rd_ready_in) begin
            exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
            `CHK("read byte", exp_b, rd_data_out)
        end
        if (!output_strobe_n_out) `CHK("bus released", 1'b0, io_oe_out)
        seed = xs(seed);
        rd_ready_in <= seed[0] | seed[1];
        wr_valid_in <= (wi < wlen);
        wr_data_in  <= page_exp[wi[3:0]];
    end
    // Fresh random page contents for the next program
    task automatic fill();
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            page_exp[i] = seed[7:0];
        end
    endtask : fill
    // One request; want is 0 done, 1 refused, 2 timeout
    task automatic run_op(input nts_pkg::nts_op_t op, input logic [31:0] addr, input logic [11:0] len, input int want);
        int got;
        got = 3;
        wi = 0;
        wlen = (op inside {nts_pkg::NTS_OP_PROG, nts_pkg::NTS_OP_CACHE_PROG}) ? int'(len) : 0;
        if (want == 0 && op inside {nts_pkg::NTS_OP_READ, nts_pkg::NTS_OP_CACHE_READ, nts_pkg::NTS_OP_COPY_READ})
            for (int i = 0; i < int'(len[10:0]); i++) exp_q.push_back(page_exp[i]);
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_op_in    <= op;
        req_addr_in  <= addr;
        req_len_in   <= len;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        // Refusal pulses right after the taking edge, so look before waiting again
        for (int i = 0; i < 5000 && got == 3; i++) begin
            #1;
            got = refused_out ? 1 : (timeout_out ? 2 : (done_out ? 0 : 3));
            if (got == 3) @(posedge clk_in);
        end
        `CHK("outcome", want, got)
        if (got == 3) complete_run();
        for (int i = 0; i < 64 && exp_q.size() > 0; i++) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
        `CHK("bytes left", 0, exp_q.size())
    endtask : run_op
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            fill();
            run_op(nts_pkg::NTS_OP_PROG, 32'h00000200, 12'h010, 0);
        end
        run_op(nts_pkg::NTS_OP_PROG, 32'h00000200, 12'h010, 1);
        run_op(nts_pkg::NTS_OP_READ, 32'h00000200, 12'h010, 0);
        run_op(nts_pkg::NTS_OP_CACHE_READ, 32'h00000200, 12'h008, 0);
        run_op(nts_pkg::NTS_OP_CACHE_READ, 32'h00000200, 12'h808, 0);
        run_op(nts_pkg::NTS_OP_COPY_READ, 32'h00000200, 12'h010, 0);
        fill();
        run_op(nts_pkg::NTS_OP_CACHE_PROG, 32'h00000400, 12'h010, 0);
        run_op(nts_pkg::NTS_OP_ERASE, 32'h00000400, 12'h000, 1);
        fill();
        run_op(nts_pkg::NTS_OP_PROG, 32'h00000400, 12'h010, 0);
        run_op(nts_pkg::NTS_OP_READ, 32'h00000400, 12'h010, 0);
        run_op(nts_pkg::NTS_OP_STATUS, 32'h00000000, 12'h000, 0);
        `CHK("status ready", 1'b1, status_out[nts_pkg::STATUS_READY_BIT])
        hang = 1'b1;
        run_op(nts_pkg::NTS_OP_ERASE, 32'h00010000, 12'h000, 2);
        hang = 1'b0;
        run_op(nts_pkg::NTS_OP_READ, 32'h00000200, 12'h010, 1);
        run_op(nts_pkg::NTS_OP_RESET, 32'h00000000, 12'h000, 0);
        run_op(nts_pkg::NTS_OP_ERASE, 32'h00010000, 12'h000, 0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
